// ### src/lurx_pkg.sv
// Package: register map, field layout and frame carrier for the receive block
`default_nettype none
package lurx_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_SIGNAL_FRAME_MATCH = 8'h14;
  localparam logic [7:0] OFF_RX_EXT_POP = 8'h18;
  localparam logic [7:0] OFF_RX_BYTE_POP = 8'h1c;
  localparam logic [7:0] OFF_RX_EXT_PEEK = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h44;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h48;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int POS_FRAMING_ERR = 15;
  localparam int POS_PARITY_ERR = 14;
  localparam int POS_RX_VALID = 5;
  localparam int POS_IRQ_SIGNAL_FRAME = 0;
  localparam int POS_IRQ_RX_VALID = 1;
  localparam int POS_IRQ_OVERFLOW = 2;
  localparam int IRQ_BITS = 3;
  localparam logic [8:0] RST_SIGNAL_FRAME_MATCH = 9'h000;
  localparam logic [IRQ_BITS-1:0] RST_IRQ = 3'h0;

  // ****************************************************************
  // Received frame with its error bits
  // ****************************************************************
  typedef struct packed {
    logic framing_error_bit;
    logic parity_error_bit;
    logic [8:0] value;
  } lurx_frame_t;

  localparam lurx_frame_t RST_FRAME = '{1'b0, 1'b0, 9'h000};

endpackage : lurx_pkg
`default_nettype wire

// ### src/lurx_head_buf.sv
// Single-entry receive buffer holding the head frame
`default_nettype none
module lurx_head_buf (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Fill side
  input wire logic wr_valid,
  input wire lurx_pkg::lurx_frame_t wr_frame,
  // Drain side
  input wire logic pop,
  output logic full,
  output lurx_pkg::lurx_frame_t head,
  output logic overflow
);

  always_ff @(posedge mclk) begin
    if (srst) begin
      full <= 1'b0;
    end else if (wr_valid) begin
      full <= 1'b1;
    end else if (pop) begin
      full <= 1'b0;
    end
  end

  // A new frame replaces an unread one; overflow reports the loss
  always_ff @(posedge mclk) begin
    if (srst) begin
      head <= lurx_pkg::RST_FRAME;
    end else if (wr_valid) begin
      head <= wr_frame;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= wr_valid && full && !pop;
    end
  end

endmodule : lurx_head_buf
`default_nettype wire

// ### src/lurx_irq.sv
// Sticky event status, enable and write-one clear, with level interrupt
`default_nettype none
module lurx_irq (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Events and software access
  input wire logic [lurx_pkg::IRQ_BITS-1:0] event_set,
  input wire logic [lurx_pkg::IRQ_BITS-1:0] clear,
  input wire logic enable_we,
  input wire logic [lurx_pkg::IRQ_BITS-1:0] enable_wdata,
  // State
  output logic [lurx_pkg::IRQ_BITS-1:0] status_q,
  output logic [lurx_pkg::IRQ_BITS-1:0] enable_q,
  output logic irq_q
);

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= lurx_pkg::RST_IRQ;
    end else begin
      status_q <= (status_q & ~clear) | event_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      enable_q <= lurx_pkg::RST_IRQ;
    end else if (enable_we) begin
      enable_q <= enable_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~clear) | event_set) & (enable_we ? enable_wdata : enable_q));
    end
  end

endmodule : lurx_irq
`default_nettype wire

// ### src/lurx_top.sv
// Receive buffer read views, signal-frame matcher and register port
//
// The plain strobed port was chosen for this implementation.
`default_nettype none

// Notes on behaviour
// - Matching received frame sets signal-frame event flag
// - Extended views report framing error in bit 15
// - Extended read returns 9 bits and pops
// - Byte read returns low 8 bits, pops
// - Peek view shows frame, errors at 15/14
// - Data-valid bit 5 high while buffer full
module lurx_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Frame from the receiver shift logic
  input wire logic rx_frame_valid,
  input wire lurx_pkg::lurx_frame_t rx_frame,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Status and interrupt
  output logic signal_frame_event_flag,
  output logic irq
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [8:0] signal_frame_match_value_q;
  logic sig_event_q;
  logic [31:0] rdata_q;
  logic buf_full;
  logic buf_overflow;
  logic pop;
  logic rx_valid_rise_q;
  logic full_prev_q;
  lurx_pkg::lurx_frame_t head;
  logic [lurx_pkg::IRQ_BITS-1:0] irq_status;
  logic [lurx_pkg::IRQ_BITS-1:0] irq_enable;
  logic [lurx_pkg::IRQ_BITS-1:0] irq_clear;
  logic [lurx_pkg::IRQ_BITS-1:0] irq_events;
  logic irq_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Pack a frame into an extended view word
  function automatic logic [31:0] ext_word(input lurx_pkg::lurx_frame_t f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[lurx_pkg::POS_FRAMING_ERR] = f.framing_error_bit;
    w[lurx_pkg::POS_PARITY_ERR] = f.parity_error_bit;
    w[8:0] = f.value;
    ext_word = w;
  endfunction : ext_word

  // ****************************************************************
  // Signal-frame match register
  // ****************************************************************
  // Only bits 8:0 are kept; reserved bits are expected as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      signal_frame_match_value_q <= lurx_pkg::RST_SIGNAL_FRAME_MATCH;
    end else if (reg_wr && hit(reg_addr, lurx_pkg::OFF_SIGNAL_FRAME_MATCH)) begin
      signal_frame_match_value_q <= reg_wdata[8:0];
    end
  end

  // Compare against every received frame, even if the buffer overflows
  always_ff @(posedge mclk) begin
    if (srst) begin
      sig_event_q <= 1'b0;
    end else begin
      sig_event_q <= rx_frame_valid && (rx_frame.value == signal_frame_match_value_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      signal_frame_event_flag <= 1'b0;
    end else begin
      signal_frame_event_flag <= irq_status[lurx_pkg::POS_IRQ_SIGNAL_FRAME];
    end
  end

  // ****************************************************************
  // Receive buffer
  // ****************************************************************
  // Only popping views drain the buffer; the peek view does not
  assign pop = reg_rd && buf_full &&
               (hit(reg_addr, lurx_pkg::OFF_RX_EXT_POP) ||
                hit(reg_addr, lurx_pkg::OFF_RX_BYTE_POP));

  lurx_head_buf u_buf (
    .mclk(mclk),
    .srst(srst),
    .wr_valid(rx_frame_valid),
    .wr_frame(rx_frame),
    .pop(pop),
    .full(buf_full),
    .head(head),
    .overflow(buf_overflow)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      full_prev_q <= 1'b0;
    end else begin
      full_prev_q <= buf_full;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_valid_rise_q <= 1'b0;
    end else begin
      rx_valid_rise_q <= buf_full && !full_prev_q;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb begin
    irq_events = '0;
    irq_events[lurx_pkg::POS_IRQ_SIGNAL_FRAME] = sig_event_q;
    irq_events[lurx_pkg::POS_IRQ_RX_VALID] = rx_valid_rise_q;
    irq_events[lurx_pkg::POS_IRQ_OVERFLOW] = buf_overflow;
  end

  assign irq_clear = (reg_wr && hit(reg_addr, lurx_pkg::OFF_IRQ_CLEAR)) ?
                     reg_wdata[lurx_pkg::IRQ_BITS-1:0] : '0;

  lurx_irq u_irq (
    .mclk(mclk),
    .srst(srst),
    .event_set(irq_events),
    .clear(irq_clear),
    .enable_we(reg_wr && hit(reg_addr, lurx_pkg::OFF_IRQ_ENABLE)),
    .enable_wdata(reg_wdata[lurx_pkg::IRQ_BITS-1:0]),
    .status_q(irq_status),
    .enable_q(irq_enable),
    .irq_q(irq_q)
  );

  assign irq = irq_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Empty buffer reads return zero rather than a stale frame
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        lurx_pkg::OFF_SIGNAL_FRAME_MATCH: rdata_q <= {23'h000000, signal_frame_match_value_q};
        lurx_pkg::OFF_RX_EXT_POP: rdata_q <= buf_full ? ext_word(head) : 32'h0;
        lurx_pkg::OFF_RX_BYTE_POP: rdata_q <= buf_full ? {24'h000000, head.value[7:0]} : 32'h0;
        lurx_pkg::OFF_RX_EXT_PEEK: rdata_q <= buf_full ? ext_word(head) : 32'h0;
        lurx_pkg::OFF_STATUS: rdata_q <= 32'(buf_full) << lurx_pkg::POS_RX_VALID;
        lurx_pkg::OFF_IRQ_STATUS: rdata_q <= {29'h0, irq_status};
        lurx_pkg::OFF_IRQ_ENABLE: rdata_q <= {29'h0, irq_enable};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : lurx_top
`default_nettype wire

// ### testbench/lurx_top_checker.sv
// Checker: timing relations at the receive block ports
`default_nettype none
module lurx_top_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Frame input
  input wire logic rx_frame_valid,
  input wire lurx_pkg::lurx_frame_t rx_frame,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status
  input wire logic signal_frame_event_flag,
  input wire logic irq
);
  // ****
  // Shadow of the match value, so frame matches can be predicted
  // ****
  logic [8:0] match_q;
  wire rd_ext = reg_rd && reg_addr == 8'h18;
  wire rd_peek = reg_rd && reg_addr == 8'h20;
  wire clr0 = reg_wr && reg_addr == 8'h44 && reg_wdata[0];
  always_ff @(posedge mclk) begin
    if (srst) begin
      match_q <= 9'h000;
    end else if (reg_wr && reg_addr == 8'h14) begin
      match_q <= reg_wdata[8:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_rdata_only_read: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data without a read");
  a_ext_pop_once: assert property (
    rd_ext && !rx_frame_valid ##1 rd_ext && !rx_frame_valid |=> reg_rdata == 32'h0)
    else $error("extended read did not remove frame");
  a_byte_low_only: assert property (
    reg_rd && reg_addr == 8'h1c |=> reg_rdata[31:8] == 24'h0)
    else $error("byte view shows upper bits");
  a_peek_no_pop: assert property (
    rd_peek && !rx_frame_valid ##1 rd_peek && !rx_frame_valid |=> $stable(reg_rdata))
    else $error("peek read changed the buffer");
  a_valid_status: assert property (
    rx_frame_valid ##1 (reg_rd && reg_addr == 8'h08) |=> reg_rdata[5])
    else $error("data valid bit low with frame held");
  a_frame_view: assert property (
    rx_frame_valid ##1 (rd_peek || rd_ext) |=> reg_rdata[15:14] == $past(rx_frame[10:9], 2)
      && reg_rdata[8:0] == $past(rx_frame[8:0], 2) && reg_rdata[13:9] == 5'h0)
    else $error("frame view differs from received frame");
  a_match_flag: assert property (
    rx_frame_valid && rx_frame.value == match_q && !reg_wr |-> ##[1:3] signal_frame_event_flag)
    else $error("matching frame raised no flag");
  a_flag_sticky: assert property (
    signal_frame_event_flag && !clr0 && !$past(clr0) |=> signal_frame_event_flag)
    else $error("flag dropped without clear");
endmodule : lurx_top_checker
bind lurx_top lurx_top_checker u_chk (.mclk(mclk), .srst(srst),
  .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .signal_frame_event_flag(signal_frame_event_flag), .irq(irq));
`default_nettype wire

// ### testbench/lurx_tx_model.sv
// Remote transmitter model: hands received frames to the block
`default_nettype none
module lurx_tx_model (
  // Clock
  input wire logic mclk,
  // Frame toward the block
  output var logic valid,
  output var lurx_pkg::lurx_frame_t frame
);
  initial begin
    valid = 1'b0;
    frame = '0;
  end
  // Idle bits are inverted so a stale frame can never pass for a new one
  task automatic send(input lurx_pkg::lurx_frame_t f, input int gap);
    repeat (gap) @(posedge mclk);
    valid <= 1'b1;
    frame <= f;
    @(posedge mclk);
    valid <= 1'b0;
    frame <= ~f;
  endtask : send
endmodule : lurx_tx_model
`default_nettype wire

// ### testbench/lurx_top_tb.sv
// Testbench: register accesses against frames from the transmitter model
`default_nettype none
module lurx_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, reg_wr, reg_rd, rx_frame_valid, signal_frame_event_flag, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  lurx_pkg::lurx_frame_t rx_frame;
  logic [7:0] offs [8] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h08, 8'h40, 8'h48, 8'h30};
  int mismatches, checked;
  lurx_top dut (.mclk(mclk), .srst(srst), .rx_frame_valid(rx_frame_valid),
    .rx_frame(rx_frame), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .signal_frame_event_flag(signal_frame_event_flag), .irq(irq));
  lurx_tx_model m (.mclk(mclk), .valid(rx_frame_valid), .frame(rx_frame));
  // ****
  // Access tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Tasks start and end on a rising edge; a clock edge passes between two strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // Read data stand one cycle and are taken at the edge that ends that cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    check(reg_rdata, exp);
  endtask : rd
  // Two reads of one offset with no gap, strobe held high across both
  task automatic rd2(input logic [7:0] a, input logic [31:0] exp1, input logic [31:0] exp2);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    @(posedge mclk);
    reg_rd <= 1'b0;
    check(reg_rdata, exp1);
    @(posedge mclk);
    check(reg_rdata, exp2);
  endtask : rd2
  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask : settle
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  // ****
  // Tests
  // ****
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    foreach (offs[i]) rd(offs[i], 32'h0);
    $display("reset values done");
    wr(8'h14, 32'h1a5);
    rd(8'h14, 32'h1a5);
    wr(8'h48, 32'h1);
    m.send('{1'b1, 1'b0, 9'h1a5}, 1);
    settle();
    check({30'h0, signal_frame_event_flag, irq}, 32'h3);
    rd(8'h40, 32'h3);
    rd(8'h08, 32'h20);
    rd2(8'h20, 32'h81a5, 32'h81a5);
    rd2(8'h18, 32'h81a5, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h44, 32'h7);
    settle();
    check({30'h0, signal_frame_event_flag, irq}, 32'h0);
    $display("extended views done");
    wr(8'h48, 32'h0);
    m.send('{1'b0, 1'b1, 9'h1a5}, 2);
    settle();
    check({30'h0, signal_frame_event_flag, irq}, 32'h2);
    rd(8'h20, 32'h41a5);
    rd(8'h1c, 32'ha5);
    rd(8'h1c, 32'h0);
    wr(8'h44, 32'h7);
    m.send('{1'b0, 1'b0, 9'h0a5}, 1);
    rd(8'h08, 32'h20);
    settle();
    check({31'h0, signal_frame_event_flag}, 32'h0);
    rd(8'h18, 32'h0a5);
    m.send('{1'b0, 1'b0, 9'h033}, 1);
    m.send('{1'b1, 1'b1, 9'h1cc}, 1);
    rd(8'h18, 32'hc1cc);
    rd(8'h40, 32'h6);
    $display("byte view and overflow done");
    complete_run();
  end
endmodule : lurx_top_tb
`default_nettype wire
